// File: design/pin_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int width = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [width-1:0] pin,
  output logic [width-1:0] level
);
  logic [width-1:0] meta_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      level <= '0;
    end else begin
      meta_q <= pin;
      level <= meta_q;
    end
  end
endmodule : pin_sync

// File: design/power_mode_control.sv
// power mode controller with its AHB-Lite register slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/100ps
module power_mode_control
#(
  parameter int restart_cycles = pwr_pkg::restart_cycles_default
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] ext_int_n,
  input wire logic irq_event,
  output logic cpu_halt,
  output logic osc_enable,
  output logic periph_enable,
  output logic [1:0] wake_vector_req,
  output logic baud_double_select
);
  import pwr_pkg::*;

  localparam bit restart_bad = (restart_cycles < restart_min_cycles) ||
    (restart_cycles > restart_max_cycles);
  if (restart_bad) begin : g_restart_bad
    $error("power_mode_control: restart_cycles outside the restart window");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pmc_q, pmc_d;
  logic [7:0] sysctl_q;
  logic [3:0] intcfg_q;
  mode_t mode_q, mode_d;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [1:0] wake_src_q;
  logic [1:0] ext_lvl;
  logic [1:0] ext_prev_q;
  logic timer_done;

  // ----------------------------------------------------------------
  // pin inputs pass two flops
  // ----------------------------------------------------------------
  pin_sync #(.width(2)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin(~ext_int_n),
    .level(ext_lvl)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire addr_ph = hsel && hready && htrans[1];
  wire wr_ph = addr_ph && hwrite;
  // only twelve address bits are decoded, so the map repeats every 4 KiB
  wire [11:0] rd_addr = haddr[11:0];
  wire hit_pmc = (wr_addr_q == power_mode_control_addr);
  wire hit_sys = (wr_addr_q == system_control_addr);
  wire hit_cfg = (wr_addr_q == int_config_addr);
  wire do_wr = wr_pend_q;
  wire [31:0] rd_mux =
    (rd_addr == power_mode_control_addr) ? {24'h000000, pmc_q} :
    (rd_addr == system_control_addr) ? {24'h000000, sysctl_q} :
    (rd_addr == int_config_addr) ? {28'h0000000, intcfg_q} :
    (rd_addr == status_addr) ? {28'h0000000, wake_src_q, mode_q} : 32'h00000000;

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  wire [1:0] ext_edge = ext_lvl & ~ext_prev_q;
  wire [1:0] int_en = intcfg_q[int_enable_lsb +: 2];
  wire [1:0] int_edge_mode = intcfg_q[int_edge_lsb +: 2];
  wire [1:0] ext_fire = int_en & ((int_edge_mode & ext_edge) | (~int_edge_mode & ext_lvl));
  wire wake_ok = sysctl_q[wake_enable_bit];
  wire [1:0] pd_wake = wake_ok ? ext_fire : 2'b00;
  wire idle_wake = irq_event || (|ext_fire);
  wire [1:0] wake_pick = pd_wake[0] ? 2'b01 : pd_wake;
  wire start_restart = (mode_q == mode_power_down) && (|pd_wake);

  restart_timer #(.cycles(restart_cycles)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(start_restart),
    .done(timer_done)
  );

  // ----------------------------------------------------------------
  // register next value
  // ----------------------------------------------------------------
  always_comb begin
    pmc_d = pmc_q;
    if (do_wr && hit_pmc) begin
      pmc_d = hwdata[7:0] & 8'h8F;
    end
    if (pmc_d[power_down_bit]) begin
      pmc_d[idle_bit] = 1'b0;
    end
    case (mode_q)
      mode_idle: begin
        if (idle_wake) pmc_d[idle_bit] = 1'b0;
      end
      mode_restart: begin
        if (timer_done) pmc_d[power_down_bit] = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      mode_run: begin
        if (pmc_q[power_down_bit]) mode_d = mode_power_down;
        else if (pmc_q[idle_bit]) mode_d = mode_idle;
      end
      mode_idle: begin
        if (idle_wake) mode_d = mode_run;
      end
      mode_power_down: begin
        if (start_restart) mode_d = mode_restart;
      end
      mode_restart: begin
        if (timer_done) mode_d = mode_run;
      end
      default: mode_d = mode_run;
    endcase
  end

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pmc_q <= power_mode_control_rst;
      sysctl_q <= system_control_rst;
      intcfg_q <= int_config_rst;
      mode_q <= mode_run;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      wake_src_q <= 2'b00;
      ext_prev_q <= 2'b00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      pmc_q <= pmc_d;
      mode_q <= mode_d;
      ext_prev_q <= ext_lvl;
      wr_pend_q <= wr_ph;
      if (addr_ph) wr_addr_q <= rd_addr;
      if (addr_ph && !hwrite) hrdata <= rd_mux;
      if (do_wr && hit_sys) sysctl_q <= hwdata[7:0] & 8'h17;
      if (do_wr && hit_cfg) intcfg_q <= hwdata[3:0];
      if (start_restart) wake_src_q <= wake_pick;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_halt <= 1'b0;
      osc_enable <= 1'b1;
      periph_enable <= 1'b1;
      wake_vector_req <= 2'b00;
      baud_double_select <= 1'b0;
    end else begin
      cpu_halt <= (mode_d != mode_run);
      // oscillator stays on in idle so timers keep counting
      osc_enable <= (mode_d == mode_run) || (mode_d == mode_idle);
      periph_enable <= (mode_d == mode_run) || (mode_d == mode_idle);
      // one-cycle vector request to the interrupt unit on resume
      wake_vector_req <= (mode_q == mode_restart && timer_done) ? wake_src_q : 2'b00;
      baud_double_select <= pmc_d[baud_double_bit];
    end
  end
endmodule : power_mode_control

// File: design/pwr_pkg.sv
// power mode control package: register map, field positions, reset values, timing
package pwr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses of aligned words)
  // ----------------------------------------------------------------
  // printed offsets are word indices, so the byte address is four times the index
  localparam logic [7:0] power_mode_control_off = 8'h87;
  localparam logic [7:0] system_control_off = 8'hBF;
  localparam logic [11:0] power_mode_control_addr = {2'b00, power_mode_control_off, 2'b00};
  localparam logic [11:0] system_control_addr = {2'b00, system_control_off, 2'b00};
  localparam logic [11:0] int_config_addr = 12'h0C0;
  localparam logic [11:0] status_addr = 12'h0C4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int idle_bit = 0;
  localparam int power_down_bit = 1;
  localparam int user_flag_zero_bit = 2;
  localparam int user_flag_one_bit = 3;
  localparam int baud_double_bit = 7;
  localparam int wake_enable_bit = 4;
  // int_config: bit0/1 enable ext int 0/1, bit2/3 edge mode for ext int 0/1
  localparam int int_enable_lsb = 0;
  localparam int int_edge_lsb = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] power_mode_control_rst = 8'h00;
  localparam logic [7:0] system_control_rst = 8'h00;
  localparam logic [3:0] int_config_rst = 4'h0;
  // ----------------------------------------------------------------
  // timing: oscillator restart, 65k to 75k oscillator cycles
  // ----------------------------------------------------------------
  localparam int restart_min_cycles = 65000;
  localparam int restart_max_cycles = 75000;
  localparam int clk_period_ns = 10;
  localparam int restart_cycles_default = restart_min_cycles;
  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_idle = 2'b01,
    mode_power_down = 2'b10,
    mode_restart = 2'b11
  } mode_t;
endpackage : pwr_pkg

// File: design/restart_timer.sv
// oscillator restart delay counter
`timescale 1ns/100ps
module restart_timer #(
  parameter int cycles = 65000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  output logic done
);
  // the down counter is twenty bits wide
  if ((cycles < 1) || (cycles > 1048575)) begin : g_cycles_bad
    $error("restart_timer: cycles out of range");
  end
  logic [19:0] count_q;
  logic running_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 20'h00000;
      running_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= 20'(cycles - 1);
        running_q <= 1'b1;
      end else if (running_q) begin
        if (count_q == 20'h00000) begin
          running_q <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 20'h00001;
        end
      end
    end
  end
endmodule : restart_timer

// File: tb/power_mode_control_monitor.sv
// checker for the power mode controller outputs
`timescale 1ns/100ps
module power_mode_control_monitor
  import pwr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic irq_event,
  input wire logic cpu_halt,
  input wire logic osc_enable,
  input wire logic periph_enable,
  input wire logic [1:0] wake_vector_req,
  input wire logic baud_double_select
);
  // ----
  // bus write tracking
  // ----
  logic wr_q;
  logic baud_q;
  logic [2:0] age_q;
  wire pm_wr = wr_q && hwdata[1:0] != 2'b00;
  wire wr_d = hsel && hready && htrans[1] && hwrite && haddr[11:0] == power_mode_control_addr;
  // age saturates so a late halt shows up instead of wrapping back to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      baud_q <= 1'b0;
      age_q <= 3'h7;
    end else begin
      wr_q <= wr_d;
      baud_q <= wr_q ? hwdata[7] : baud_q;
      age_q <= pm_wr ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  osc_periph_a: assert property (osc_enable == periph_enable)
    else $error("peripheral enable differs from oscillator");
  pd_halts_a: assert property (!osc_enable |-> cpu_halt)
    else $error("oscillator off while processor runs");
  pd_enter_a: assert property (wr_q && hwdata[1] |-> ##[1:3] !osc_enable)
    else $error("power-down not entered");
  idle_enter_a: assert property (wr_q && hwdata[1:0] == 2'b01 && !irq_event
    |-> ##[1:3] (cpu_halt && osc_enable)) else $error("idle not entered");
  idle_exit_a: assert property (cpu_halt && osc_enable && irq_event
    |-> ##[1:4] !cpu_halt) else $error("idle not left");
  vec_pulse_a: assert property (wake_vector_req != 2'b00
    |=> wake_vector_req == 2'b00) else $error("vector request too long");
  vec_resume_a: assert property (wake_vector_req != 2'b00
    |-> ##[0:3] (!cpu_halt && osc_enable)) else $error("no resume after vector");
  halt_cause_a: assert property ($rose(cpu_halt) |-> age_q <= 3'h3)
    else $error("halt without mode write");
  baud_follow_a: assert property (wr_q |-> ##2 baud_double_select == baud_q)
    else $error("baud select not written");
  cover property ($rose(cpu_halt) && osc_enable);
  cover property ($fell(osc_enable));
  cover property (wake_vector_req != 2'b00);
endmodule : power_mode_control_monitor
bind power_mode_control power_mode_control_monitor i_mon (.clk, .arst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .irq_event, .cpu_halt, .osc_enable, .periph_enable,
  .wake_vector_req, .baud_double_select);

// File: tb/tb_power_mode_control.sv
// testbench for the power mode controller
`timescale 1ns/100ps
module tb_power_mode_control;
  import pwr_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_event = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, ext_int_n = 2'h3, wake_vector_req;
  logic hreadyout, hresp, cpu_halt, osc_enable, periph_enable, baud_double_select;
  int mismatches = 0, samples_checked = 0;
  always #5 clk = ~clk;
  // hsize is ignored by the slave, and hready is the slave's own hreadyout
  power_mode_control i_dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_int_n, .irq_event,
    .cpu_halt, .osc_enable, .periph_enable, .wake_vector_req, .baud_double_select);
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
    check(32'(hresp), 32'h0);
  endtask : rd
  // levels are sampled mid-cycle so the edge's own updates have landed
  task automatic wait_halt(input logic h, input logic o, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (!(cpu_halt === h && osc_enable === o) && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({30'h0, cpu_halt, osc_enable}, {30'h0, h, o});
    @(posedge clk);
  endtask : wait_halt
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(power_mode_control_addr, 32'h0);
    wr(power_mode_control_addr, 32'hFFFF_FFFC);
    rd(power_mode_control_addr, 32'h8C);
    check(32'(baud_double_select), 32'h1);
    wr(power_mode_control_addr, 32'h4);
    rd(power_mode_control_addr, 32'h4);
    check(32'(baud_double_select), 32'h0);
    wr(system_control_addr, 32'h10);
    rd(system_control_addr, 32'h10);
    rd(12'h040, 32'h0);
  endtask : t_regs
  task automatic t_idle;
    wr(power_mode_control_addr, 32'h1);
    wait_halt(1'b1, 1'b1, 8);
    rd(power_mode_control_addr, 32'h1);
    irq_event <= 1'b1;
    wait_halt(1'b0, 1'b1, 8);
    irq_event <= 1'b0;
    rd(power_mode_control_addr, 32'h0);
  endtask : t_idle
  task automatic t_pd_block;
    wr(system_control_addr, 32'h0);
    wr(int_config_addr, 32'h3);
    wr(power_mode_control_addr, 32'h3);
    wait_halt(1'b1, 1'b0, 8);
    rd(power_mode_control_addr, 32'h2);
    rd(status_addr, 32'h2);
    ext_int_n <= 2'h0;
    repeat (50) @(posedge clk);
    wait_halt(1'b1, 1'b0, 0);
    arst_n <= 1'b0;
    wait_halt(1'b0, 1'b1, 0);
    arst_n <= 1'b1;
    ext_int_n <= 2'h3;
  endtask : t_pd_block
  task automatic t_pd_wake;
    int n;
    rd(power_mode_control_addr, 32'h0);
    wr(system_control_addr, 32'h10);
    wr(int_config_addr, 32'hA);
    wr(power_mode_control_addr, 32'h2);
    wait_halt(1'b1, 1'b0, 8);
    rd(int_config_addr, 32'hA);
    ext_int_n <= 2'h2;
    repeat (20) @(posedge clk);
    wait_halt(1'b1, 1'b0, 0);
    ext_int_n <= 2'h1;
    n = 0;
    @(negedge clk);
    while (wake_vector_req === 2'h0 && n < 80000) begin
      @(negedge clk);
      n++;
    end
    check(32'(wake_vector_req), 32'h2);
    check(32'(n >= restart_min_cycles && n <= restart_max_cycles), 32'h1);
    @(posedge clk);
    ext_int_n <= 2'h3;
    wait_halt(1'b0, 1'b1, 4);
    rd(status_addr, 32'h8);
    rd(power_mode_control_addr, 32'h0);
  endtask : t_pd_wake
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_idle();
    t_pd_block();
    t_pd_wake();
    wrap_up();
  end
  // one restart delay plus a few hundred bus cycles fits well inside this span
  initial begin
    #900us;
    mismatches++;
    wrap_up();
  end
endmodule : tb_power_mode_control
